// file: include/fan_regs.svh
`ifndef FAN_REGS_SVH
`define FAN_REGS_SVH

`define CLK_HZ          20000000
`define CYC_PER_US      (`CLK_HZ / 1000000)
`define CYC_PER_MS      (`CLK_HZ / 1000)

// analog levels carried as millivolt codes
`define MV_ZERO_DUTY    12'h0bb8
`define MV_FULL_DUTY    12'h03e8
`define MV_LOCK_HI      12'h0bb8
`define MV_LOCK_LO      12'h03e8
`define MV_RESET        12'h0000

// restart timing, times as printed
`define T_ON_MS         560
`define T_OFF_MS        6800
`define CHARGE_STEP_CYC ((`T_ON_MS * `CYC_PER_MS) / 2000)
`define DISCH_STEP_CYC  ((`T_OFF_MS * `CYC_PER_MS) / 2000)

// commutation delay
`define COM_DEL_US      100
`define COM_DEL_CYC     (`COM_DEL_US * `CYC_PER_US)

// pwm ramp and current-limit slew
`define PWM_STEP_MV     12'h0005
`define LIMIT_STEP_CYC  8'h14
`define LIMIT_MAX_MV    12'h07d0

`endif

// file: include/fan_pkg.sv
package fan_pkg;
	typedef logic [11:0] mv_t;
	typedef logic [16:0] cyc_t;
	typedef enum logic [1:0] {
		LOCK_RUN,
		LOCK_WAIT,
		LOCK_DRIVE
	} lock_state_e;
endpackage

// file: include/fan_duty_if.sv
interface fan_duty_if;
	import fan_pkg::*;
	mv_t  spd_mv;
	mv_t  min_speed_in_mv;
	mv_t  sense_mv;
	mv_t  thresh_mv;
	logic pwm_on;
	modport ctrl (output spd_mv, output min_speed_in_mv, output sense_mv, output thresh_mv,
		input pwm_on);
	modport pwm (input spd_mv, input min_speed_in_mv, input sense_mv, input thresh_mv,
		output pwm_on);
endinterface

// file: rtl/fan_pwm.sv
`include "fan_regs.svh"

module fan_pwm
	import fan_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic rst_i,
	fan_duty_if.pwm   duty
);

	mv_t        ramp;
	mv_t        next_ramp;
	mv_t        corr;
	mv_t        next_corr;
	logic [7:0] tick_cnt;
	logic [7:0] next_tick_cnt;
	logic       pwm_q;
	logic       next_pwm_q;
	logic [12:0] sum_mv;
	mv_t        eff_mv;

	// sawtooth between the two duty levels, like the timing capacitor
	always_comb begin
		if (ramp >= `MV_ZERO_DUTY - `PWM_STEP_MV) begin
			next_ramp = `MV_FULL_DUTY;
		end else begin
			next_ramp = ramp + `PWM_STEP_MV;
		end
	end

	// slow slew of the correction so the loop does not ring
	always_comb begin
		next_tick_cnt = tick_cnt + 8'h01;
		next_corr     = corr;
		if (tick_cnt >= `LIMIT_STEP_CYC - 8'h01) begin
			next_tick_cnt = 8'h00;
			if (duty.sense_mv > duty.thresh_mv) begin
				if (corr < `LIMIT_MAX_MV) begin
					next_corr = corr + 12'h001;
				end
			end else if (corr != 12'h000) begin
				next_corr = corr - 12'h001;
			end
		end
	end

	// demand plus correction, clamped at the minimum-speed level
	always_comb begin
		sum_mv = {1'b0, duty.spd_mv} + {1'b0, corr};
		if (sum_mv > {1'b0, duty.min_speed_in_mv}) begin
			eff_mv = duty.min_speed_in_mv;
		end else begin
			eff_mv = sum_mv[11:0];
		end
		// higher demand voltage means lower duty
		next_pwm_q = (duty.spd_mv <= `MV_ZERO_DUTY) && (ramp >= eff_mv);
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ramp     <= `MV_FULL_DUTY;
			corr     <= `MV_RESET;
			tick_cnt <= 8'h00;
			pwm_q    <= 1'b0;
		end else begin
			ramp     <= next_ramp;
			corr     <= next_corr;
			tick_cnt <= next_tick_cnt;
			pwm_q    <= next_pwm_q;
		end
	end

	assign duty.pwm_on = pwm_q;

endmodule

// file: rtl/fan_ctrl.sv
`include "fan_regs.svh"

module fan_ctrl
	import fan_pkg::*;
#(
	parameter cyc_t CHARGE_STEP_CYC = 17'(`CHARGE_STEP_CYC),
	parameter cyc_t DISCH_STEP_CYC  = 17'(`DISCH_STEP_CYC)
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        hall_high_i,
	input  wire logic [11:0] speed_demand_in_i,
	input  wire logic [11:0] min_speed_in_i,
	input  wire logic [11:0] current_sense_i,
	input  wire logic [11:0] current_threshold_in_i,
	input  wire logic [11:0] commutation_delay_adj_i,
	output logic             speed_pulse_out_o,
	output logic             speed_pulse_out_oe_o,
	output logic             locked_flag_o,
	output logic             locked_flag_oe_o,
	output logic             low_side_drive_a_o,
	output logic             low_side_drive_b_o,
	output logic             high_side_drive_a_o,
	output logic             high_side_drive_b_o,
	output logic [11:0]      lock_timing_cap_o
);

	localparam int unsigned SYNC_W = 61;

	// pin synchronisers, two stages before any logic looks
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	logic [SYNC_W-1:0] next_sync_a;
	logic [SYNC_W-1:0] next_sync_b;

	logic hall_s;
	mv_t  spd_s;
	mv_t  min_speed_in_s;
	mv_t  sense_s;
	mv_t  thresh_s;
	mv_t  commutation_delay_adj_s;

	// hall edge and commutation delay
	logic hall_d;
	logic next_hall_d;
	logic hall_edge;
	cyc_t del_cnt;
	cyc_t next_del_cnt;
	logic del_pend;
	logic next_del_pend;
	logic phase_b;
	logic next_phase_b;
	cyc_t del_load;

	// lock timing
	lock_state_e state;
	lock_state_e next_state;
	mv_t         cap;
	mv_t         next_cap;
	cyc_t        div;
	cyc_t        next_div;
	cyc_t        div_rate;
	logic        div_step;

	// registered outputs and the drive enable
	logic fg_q;
	logic next_fg_q;
	logic rd_q;
	logic next_rd_q;
	logic lo_a;
	logic lo_b;
	logic hi_a;
	logic hi_b;
	logic next_lo_a;
	logic next_lo_b;
	logic next_hi_a;
	logic next_hi_b;
	logic drive_en;

	fan_duty_if duty ();

	// synchroniser stages
	always_comb begin
		next_sync_a = {hall_high_i, speed_demand_in_i, min_speed_in_i, current_sense_i,
			current_threshold_in_i, commutation_delay_adj_i};
		next_sync_b = sync_a;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
		end
	end

	assign hall_s   = sync_b[60];
	assign spd_s    = sync_b[59:48];
	assign min_speed_in_s   = sync_b[47:36];
	assign sense_s  = sync_b[35:24];
	assign thresh_s = sync_b[23:12];
	assign commutation_delay_adj_s = sync_b[11:0];

	// demand path to the pwm block
	assign duty.spd_mv    = spd_s;
	assign duty.min_speed_in_mv   = min_speed_in_s;
	assign duty.sense_mv  = sense_s;
	assign duty.thresh_mv = thresh_s;

	fan_pwm u_pwm (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.duty   (duty.pwm)
	);

	// delay in microseconds, zero selects the nominal figure
	always_comb begin
		if (commutation_delay_adj_s == 12'h000) begin
			del_load = 17'(`COM_DEL_CYC);
		end else begin
			del_load = 17'(commutation_delay_adj_s * 17'(`CYC_PER_US));
		end
	end

	assign hall_edge = hall_s ^ hall_d;

	// phase follows hall only after the delay; a new edge restarts it
	always_comb begin
		next_hall_d   = hall_s;
		next_del_cnt  = del_cnt;
		next_del_pend = del_pend;
		next_phase_b  = phase_b;
		if (hall_edge) begin
			next_del_cnt  = del_load;
			next_del_pend = 1'b1;
		end else if (del_pend) begin
			if (del_cnt <= 17'h0_0001) begin
				next_del_pend = 1'b0;
				next_phase_b  = hall_s;
				next_del_cnt  = 17'h0_0000;
			end else begin
				next_del_cnt = del_cnt - 17'h0_0001;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			hall_d   <= 1'b0;
			del_cnt  <= 17'h0_0000;
			del_pend <= 1'b0;
			phase_b  <= 1'b0;
		end else begin
			hall_d   <= next_hall_d;
			del_cnt  <= next_del_cnt;
			del_pend <= next_del_pend;
			phase_b  <= next_phase_b;
		end
	end

	// cap charges slowly, discharges twelve times slower
	assign div_rate = (state == LOCK_WAIT) ? DISCH_STEP_CYC : CHARGE_STEP_CYC;
	assign div_step = (div >= div_rate - 17'h0_0001);

	// lock detector modelled as a capacitor voltage in millivolts
	always_comb begin
		next_state = state;
		next_cap   = cap;
		next_div   = div_step ? 17'h0_0000 : div + 17'h0_0001;
		case (state)
			LOCK_RUN: begin
				if (hall_edge) begin
					next_cap = `MV_RESET;
					next_div = 17'h0_0000;
				end else if (div_step) begin
					if (cap >= `MV_LOCK_HI - 12'h001) begin
						next_cap   = `MV_LOCK_HI;
						next_state = LOCK_WAIT;
					end else begin
						next_cap = cap + 12'h001;
					end
				end
			end
			LOCK_WAIT: begin
				if (hall_edge) begin
					next_state = LOCK_RUN;
					next_cap   = `MV_RESET;
					next_div   = 17'h0_0000;
				end else if (div_step) begin
					if (cap <= `MV_LOCK_LO + 12'h001) begin
						next_cap   = `MV_LOCK_LO;
						next_state = LOCK_DRIVE;
					end else begin
						next_cap = cap - 12'h001;
					end
				end
			end
			LOCK_DRIVE: begin
				if (hall_edge) begin
					next_state = LOCK_RUN;
					next_cap   = `MV_RESET;
					next_div   = 17'h0_0000;
				end else if (div_step) begin
					if (cap >= `MV_LOCK_HI - 12'h001) begin
						next_cap   = `MV_LOCK_HI;
						next_state = LOCK_WAIT;
					end else begin
						next_cap = cap + 12'h001;
					end
				end
			end
			default: begin
				next_state = LOCK_RUN;
				next_cap   = `MV_RESET;
				next_div   = 17'h0_0000;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state <= LOCK_RUN;
			cap   <= `MV_RESET;
			div   <= 17'h0_0000;
		end else begin
			state <= next_state;
			cap   <= next_cap;
			div   <= next_div;
		end
	end

	// only the wait phase of a stall removes drive
	assign drive_en = (state != LOCK_WAIT);

	// bridge and flag outputs, registered so no glitch reaches the gates
	always_comb begin
		next_fg_q = hall_s;
		next_rd_q = (state != LOCK_RUN);
		next_lo_a = drive_en && !phase_b && duty.pwm_on;
		next_lo_b = drive_en && phase_b && duty.pwm_on;
		next_hi_a = drive_en && !phase_b;
		next_hi_b = drive_en && phase_b;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fg_q <= 1'b0;
			rd_q <= 1'b0;
			lo_a <= 1'b0;
			lo_b <= 1'b0;
			hi_a <= 1'b0;
			hi_b <= 1'b0;
		end else begin
			fg_q <= next_fg_q;
			rd_q <= next_rd_q;
			lo_a <= next_lo_a;
			lo_b <= next_lo_b;
			hi_a <= next_hi_a;
			hi_b <= next_hi_b;
		end
	end

	// open-drain pins: data always low, enable pulls the wire down
	assign speed_pulse_out_o    = 1'b0;
	assign speed_pulse_out_oe_o = !fg_q;
	assign locked_flag_o        = 1'b0;
	assign locked_flag_oe_o     = !rd_q;

	assign low_side_drive_a_o  = lo_a;
	assign low_side_drive_b_o  = lo_b;
	assign high_side_drive_a_o = hi_a;
	assign high_side_drive_b_o = hi_b;
	assign lock_timing_cap_o   = cap;

endmodule

// file: verif/fan_ctrl_sva.sv
module fan_ctrl_sva (
	input wire logic        mclk_i,
	input wire logic        rst_i,
	input wire logic        hall_high_i,
	input wire logic [11:0] speed_demand_in_i,
	input wire logic        speed_pulse_out_oe_o,
	input wire logic        locked_flag_oe_o,
	input wire logic        low_side_drive_a_o,
	input wire logic        low_side_drive_b_o,
	input wire logic        high_side_drive_a_o,
	input wire logic        high_side_drive_b_o,
	input wire logic [11:0] lock_timing_cap_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// two sync flops plus the output flop
	chk_fg_rise: assert property (
		$rose(hall_high_i) ##1 hall_high_i [*2] |=> !speed_pulse_out_oe_o) else $error("fg");
	chk_lock_off: assert property (
		$fell(locked_flag_oe_o) |-> !(low_side_drive_a_o || low_side_drive_b_o
		|| high_side_drive_a_o || high_side_drive_b_o)) else $error("lock drive");
	chk_idle_low: assert property (
		high_side_drive_a_o |-> !low_side_drive_b_o && !high_side_drive_b_o) else $error("idle");
	chk_low_phase: assert property (
		(!low_side_drive_a_o || high_side_drive_a_o)
		&& (!low_side_drive_b_o || high_side_drive_b_o)) else $error("phase");
	chk_wait_off: assert property (
		!locked_flag_oe_o && lock_timing_cap_o == $past(lock_timing_cap_o) - 12'h001
		|-> !high_side_drive_a_o && !high_side_drive_b_o) else $error("wait");
	chk_cap_max: assert property (
		lock_timing_cap_o <= 12'h0bb8) else $error("cap");
	chk_unlock_edge: assert property (
		$changed(hall_high_i) && !locked_flag_oe_o ##1 $stable(hall_high_i) [*3]
		|-> ##[1:4] locked_flag_oe_o) else $error("unlock");
	chk_spd_off: assert property (
		(speed_demand_in_i > 12'h0bb8) [*8]
		|-> !low_side_drive_a_o && !low_side_drive_b_o) else $error("spd off");
endmodule

bind fan_ctrl fan_ctrl_sva fan_ctrl_sva_i (.mclk_i(mclk_i), .rst_i(rst_i),
	.hall_high_i(hall_high_i), .speed_demand_in_i(speed_demand_in_i),
	.speed_pulse_out_oe_o(speed_pulse_out_oe_o), .locked_flag_oe_o(locked_flag_oe_o),
	.low_side_drive_a_o(low_side_drive_a_o), .low_side_drive_b_o(low_side_drive_b_o),
	.high_side_drive_a_o(high_side_drive_a_o), .high_side_drive_b_o(high_side_drive_b_o),
	.lock_timing_cap_o(lock_timing_cap_o));

// file: verif/fan_rotor.sv
module fan_rotor #(
	parameter int HALF = 1500
) (
	input  wire logic mclk_i,
	input  wire logic turn_i,
	input  wire logic drive_i,
	output logic      hall_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial hall_o = 1'b0;
	// rotor only advances while free and powered; a stall freezes hall
	always @(posedge mclk_i) begin
		if (turn_i && drive_i) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) hall_o <= #1 ~hall_o;
		end else begin
			cnt <= 0;
		end
	end
endmodule

// file: verif/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 1'b0;
	logic        rst_i  = 1'b1;
	logic        turn   = 1'b0;
	logic [11:0] speed_demand_in    = 12'h07d0;
	logic [11:0] min_speed_in   = 12'h0fff;
	logic [11:0] sense  = 12'h0000;
	logic [11:0] commutation_delay_adj = 12'h0032;
	logic        hall, fg_oe, rd_oe, la, lb, ha, hb, hi, fg_d, rd_d, ph_ok;
	logic [11:0] cap;
	int          error_cnt  = 0;
	int          num_checks = 0;
	int          n;
	assign hi = ha | hb;
	// phase outputs agree with the latest hall level
	assign ph_ok = (hb == hall) && (ha != hall);
	// open-drain pins seen through an external pull-up; data shows while enabled
	wire fg_w = fg_oe ? fg_d : 1'b1;
	wire rd_w = rd_oe ? rd_d : 1'b1;
	fan_rotor #(.HALF(1500)) fan_rotor_i (.mclk_i(mclk_i), .turn_i(turn), .drive_i(hi),
		.hall_o(hall));
	// short lock steps keep the restart cycle at 3000/24000/2000 cycles
	fan_ctrl #(.CHARGE_STEP_CYC(17'h1), .DISCH_STEP_CYC(17'hc)) fan_ctrl_i (
		.mclk_i(mclk_i), .rst_i(rst_i), .hall_high_i(hall), .speed_demand_in_i(speed_demand_in),
		.min_speed_in_i(min_speed_in), .current_sense_i(sense), .current_threshold_in_i(12'h0064),
		.commutation_delay_adj_i(commutation_delay_adj), .speed_pulse_out_o(fg_d),
		.speed_pulse_out_oe_o(fg_oe), .locked_flag_o(rd_d), .locked_flag_oe_o(rd_oe),
		.low_side_drive_a_o(la), .low_side_drive_b_o(lb), .high_side_drive_a_o(ha),
		.high_side_drive_b_o(hb), .lock_timing_cap_o(cap));
	initial begin
		forever #25 mclk_i = ~mclk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	// bounded wait, cycle count left in n
	task automatic wait_on(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 30000) begin
			cyc(1);
			n++;
		end
	endtask
	// one full sawtooth period gives an exact on count
	task automatic duty();
		n = 0;
		repeat (400) begin
			cyc(1);
			n += int'(la | lb);
		end
	endtask
	task automatic results();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic t_commute();
		chk({fg_w, rd_w}, 0);
		turn = 1'b1;
		wait_on(hall, 1'b1);
		cyc(5);
		chk(fg_w, 1);
		wait_on(hb, 1'b1);
		chk(n inside {[990:1010]}, 1);
		chk({la, ha}, 0);
		duty();
		chk(n, 200);
	endtask
	task automatic t_limit();
		sense = 12'h00c8;
		cyc(4000);
		duty();
		chk(n < 200, 1);
		min_speed_in = 12'h0834;
		cyc(20);
		duty();
		chk(n, 180);
		sense = 12'h0000;
		min_speed_in = 12'h0fff;
		cyc(8000);
		duty();
		chk(n, 200);
		speed_demand_in = 12'h0bb9;
		cyc(10);
		duty();
		chk(n, 0);
		speed_demand_in = 12'h07d0;
	endtask
	task automatic t_lock();
		int m;
		@(hall);
		turn = 1'b0;
		// zero selects the nominal delay; it rides the same sync chain as hall
		commutation_delay_adj = 12'h000;
		wait_on(ph_ok, 1'b1);
		chk(n inside {[1995:2012]}, 1);
		m = n;
		wait_on(rd_oe, 1'b0);
		chk((m + n) inside {[2995:3012]}, 1);
		chk({rd_w, ha, hb, la, lb}, 5'b10000);
		wait_on(hi, 1'b1);
		chk(n inside {[23990:24010]}, 1);
		wait_on(hi, 1'b0);
		chk(n inside {[1995:2005]}, 1);
		chk(rd_w, 1);
		wait_on(hi, 1'b1);
		chk(n inside {[23990:24010]}, 1);
		turn = 1'b1;
		wait_on(rd_oe, 1'b1);
		chk(n inside {[1495:1515]}, 1);
	endtask
	initial begin
		repeat (4) @(posedge mclk_i);
		#1;
		chk({fg_oe, rd_oe, la, lb, ha, hb, cap}, 18'h3_0000);
		rst_i = 1'b0;
		t_commute();
		t_limit();
		t_lock();
		results();
	end
	// about 72000 cycles expected
	initial begin
		#4_500_000;
		error_cnt++;
		results();
	end
endmodule
